//--- core/serial_cfg_pkg.sv
// constants, encodings and state types of the host serial port
// assumes a single 10 MHz clock and synchronous active-high reset
// Operation
// - codes 0..8 pick standard rates, reset 9600
// - values 0x4B0..0x3D090 are literal bit rates
// - literal rate rounded, achieved value stored
// - new rate drives receiver and transmitter
// - rate readback shows the stored value
// - serial rate never touches radio rate
// - parity none, even, odd, mark; reset none
// - received parity never checked or rejected
// - packet sent after configured silence time
// - full payload sends packet immediately
// - zero timeout forwards each character alone
// - cts pin off, flow, input, low, high
// - function 6 low while transmitting
// - function 7 high while transmitting
// - framed mode off means raw silence-delimited bytes
package serial_cfg_pkg;
    // clock
    localparam int          CLK_PERIOD_NS = 100;
    localparam logic [23:0] CLK_HZ        = 24'h98_9680; // 10 MHz
    // rate setting
    localparam logic [19:0] STD_CODE_MAX = 20'h0_0008;
    localparam logic [19:0] RATE_LIT_MIN = 20'h0_04B0;
    localparam logic [19:0] RATE_LIT_MAX = 20'h3_D090;
    localparam logic [19:0] RATE_RESET   = 20'h0_0003;
    localparam logic [15:0] DIV_RESET    = 16'h0412; // 10 MHz / 9600
    localparam logic [19:0] STD_RATE [0:8] = '{
        20'h0_04B0, 20'h0_0960, 20'h0_12C0, 20'h0_2580, 20'h0_4B00,
        20'h0_9600, 20'h0_E100, 20'h1_C200, 20'h3_8400};
    localparam logic [4:0]  DIV_STEPS    = 5'h18; // quotient bits
    // parity setting
    localparam logic [1:0]  PAR_NONE  = 2'h0;
    localparam logic [1:0]  PAR_EVEN  = 2'h1;
    localparam logic [1:0]  PAR_ODD   = 2'h2;
    localparam logic [1:0]  PAR_MARK  = 2'h3;
    localparam logic [1:0]  PAR_RESET = 2'h0;
    // packetizer
    localparam logic [7:0]  TIMEOUT_RESET = 8'h03;
    localparam int          BUF_AW        = 7;
    localparam logic [7:0]  BUF_DEPTH     = 8'h80;
    localparam logic [7:0]  MAX_PAYLOAD   = 8'h64;
    localparam logic [7:0]  NEAR_FULL     = 8'h70;
    localparam logic [3:0]  BITS_NO_PAR   = 4'hA; // start, 8 data, stop
    // flow pin functions
    localparam logic [2:0]  PIN_OFF    = 3'h0;
    localparam logic [2:0]  PIN_FLOW   = 3'h1;
    localparam logic [2:0]  PIN_DIN    = 3'h3;
    localparam logic [2:0]  PIN_LOW    = 3'h4;
    localparam logic [2:0]  PIN_HIGH   = 3'h5;
    localparam logic [2:0]  PIN_485_LO = 3'h6;
    localparam logic [2:0]  PIN_485_HI = 3'h7;
    localparam logic [2:0]  CTS_FN_RESET = PIN_FLOW;
    localparam logic [2:0]  RTS_FN_RESET = PIN_OFF;
    // states
    typedef enum logic [2:0] {
        R_IDLE = 3'b001, R_DIV1 = 3'b010, R_DIV2 = 3'b100
    } rate_state_t;
    typedef enum logic [2:0] {
        RX_IDLE = 3'b001, RX_START = 3'b010, RX_DATA = 3'b100
    } rx_state_t;
    typedef enum logic [2:0] {
        D_IDLE = 3'b001, D_FETCH = 3'b010, D_SEND = 3'b100
    } drain_state_t;
endpackage

//--- core/rx_buffer_mem.sv
// serial receive buffer storage, one write and one read port
// assumes the caller keeps pointers in range and never overfills
`timescale 1ns/1ps
module rx_buffer_mem (
    input  wire logic                              sys_clk_i,
    input  wire logic                              wr_en_i,
    input  wire logic [serial_cfg_pkg::BUF_AW-1:0] wr_addr_i,
    input  wire logic [7:0]                        wr_data_i,
    input  wire logic                              rd_en_i,
    input  wire logic [serial_cfg_pkg::BUF_AW-1:0] rd_addr_i,
    output logic      [7:0]                        rd_data_o
);
    import serial_cfg_pkg::*;
    logic [7:0] mem [0:(1<<BUF_AW)-1]; // byte storage

    // write port and registered read port
    always_ff @(posedge sys_clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        if (rd_en_i) begin
            rd_data_o <= mem[rd_addr_i];
        end
    end
endmodule

//--- core/host_serial_port_config.sv
// host serial port: rate, parity, packetizer and flow pins
// assumes host pins already synchronous to sys_clk_i
`timescale 1ns/1ps
module host_serial_port_config (
    input  wire logic                sys_clk_i,
    input  wire logic                rst_i,
    input  wire logic                rate_wr_i,
    input  wire logic                parity_wr_i,
    input  wire logic                timeout_wr_i,
    input  wire logic                cts_fn_wr_i,
    input  wire logic                rts_fn_wr_i,
    input  wire logic [19:0]         cfg_wdata_i,
    input  wire logic                framed_mode_i,
    output logic      [19:0]         interface_rate_setting_o,
    output logic                     rate_busy_o,
    output logic      [1:0]          parity_setting_o,
    output logic      [7:0]          packet_silence_timeout_o,
    output logic      [2:0]          cts_pin_function_o,
    output logic      [2:0]          rts_pin_function_o,
    input  wire logic                uart_rx_i,
    output logic                     uart_tx_o,
    output logic                     rf_tx_valid_o,
    output logic      [7:0]          rf_tx_data_o,
    output logic                     rf_tx_last_o,
    input  wire logic                rf_tx_ready_i,
    input  wire logic                rf_rx_valid_i,
    input  wire logic [7:0]          rf_rx_data_i,
    output logic                     rf_rx_ready_o,
    input  wire logic                flow_pin_seven_i,
    output logic                     flow_pin_seven_o,
    output logic                     flow_pin_seven_oe_o,
    output logic                     flow_pin_seven_din_o,
    input  wire logic                flow_pin_six_i,
    output logic                     flow_pin_six_o,
    output logic                     flow_pin_six_oe_o,
    output logic                     flow_pin_six_din_o
);
    import serial_cfg_pkg::*;
    // checks below share this clock and reset
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    rate_state_t  rst_q, rst_d;       // rate engine state
    logic [19:0]  rate_q, rate_d;     // stored rate setting
    logic [19:0]  pend_q, pend_d;     // code awaiting completion
    logic         code_q, code_d;     // standard code in flight
    logic [15:0]  div_q, div_d;       // clocks per bit
    logic [23:0]  divd_q, divd_d;     // dividend shifter
    logic [19:0]  dvsr_q, dvsr_d;     // divisor
    logic [20:0]  rem_q, rem_d;       // partial remainder
    logic [23:0]  quo_q, quo_d;       // quotient
    logic [4:0]   it_q, it_d;         // steps left
    logic [1:0]   par_q, par_d;       // parity setting
    logic [7:0]   to_q, to_d;         // silence timeout
    logic [2:0]   cfn_q, cfn_d;       // cts pin function
    logic [2:0]   rfn_q, rfn_d;       // rts pin function
    logic [20:0]  rem_n;              // shifted remainder
    logic         ge;                 // divisor fits

    // rate engine: code lookup or literal rounding by division
    always_comb begin
        rst_d = rst_q; rate_d = rate_q; pend_d = pend_q; code_d = code_q;
        div_d = div_q; divd_d = divd_q; dvsr_d = dvsr_q; rem_d = rem_q;
        quo_d = quo_q; it_d = it_q;
        rem_n = {rem_q[19:0], divd_q[23]};
        ge = rem_n >= {1'b0, dvsr_q};
        unique case (rst_q)
            R_IDLE: begin
                // unsupported values leave everything unchanged
                if (rate_wr_i && cfg_wdata_i <= STD_CODE_MAX) begin
                    code_d = 1'b1;
                    pend_d = cfg_wdata_i;
                    dvsr_d = STD_RATE[cfg_wdata_i[3:0]];
                    rst_d  = R_DIV1;
                end else if (rate_wr_i && cfg_wdata_i >= RATE_LIT_MIN &&
                             cfg_wdata_i <= RATE_LIT_MAX) begin
                    code_d = 1'b0;
                    dvsr_d = cfg_wdata_i;
                    rst_d  = R_DIV1;
                end
                divd_d = CLK_HZ + {5'h00, dvsr_d[19:1]}; // rounded quotient
                rem_d  = '0;
                quo_d  = '0;
                it_d   = DIV_STEPS;
            end
            default: begin
                // one restoring-division step per clock
                rem_d  = ge ? rem_n - {1'b0, dvsr_q} : rem_n;
                quo_d  = {quo_q[22:0], ge};
                divd_d = {divd_q[22:0], 1'b0};
                it_d   = it_q - 5'h01;
                if (it_q == 5'h01 && rst_q == R_DIV1) begin
                    div_d = quo_d[15:0];
                    if (code_q) begin
                        rate_d = pend_q;
                        rst_d  = R_IDLE;
                    end else begin
                        // achieved rate from the chosen divider
                        dvsr_d = {4'h0, quo_d[15:0]};
                        divd_d = CLK_HZ + {9'h000, quo_d[15:1]};
                        rem_d  = '0;
                        it_d   = DIV_STEPS;
                        rst_d  = R_DIV2;
                    end
                end else if (it_q == 5'h01) begin
                    rate_d = quo_d[19:0];
                    rst_d  = R_IDLE;
                end
            end
        endcase
        par_d = parity_wr_i ? cfg_wdata_i[1:0] : par_q;
        to_d  = timeout_wr_i ? cfg_wdata_i[7:0] : to_q;
        cfn_d = cts_fn_wr_i ? cfg_wdata_i[2:0] : cfn_q;
        rfn_d = rts_fn_wr_i ? cfg_wdata_i[2:0] : rfn_q;
    end

    // rate and settings registers
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rst_q <= R_IDLE; rate_q <= RATE_RESET; pend_q <= RATE_RESET;
            code_q <= 1'b1; div_q <= DIV_RESET; divd_q <= '0;
            dvsr_q <= '0; rem_q <= '0; quo_q <= '0; it_q <= '0;
            par_q <= PAR_RESET; to_q <= TIMEOUT_RESET;
            cfn_q <= CTS_FN_RESET; rfn_q <= RTS_FN_RESET;
        end else begin
            rst_q <= rst_d; rate_q <= rate_d; pend_q <= pend_d;
            code_q <= code_d; div_q <= div_d; divd_q <= divd_d;
            dvsr_q <= dvsr_d; rem_q <= rem_d; quo_q <= quo_d; it_q <= it_d;
            par_q <= par_d; to_q <= to_d; cfn_q <= cfn_d; rfn_q <= rfn_d;
        end
    end

    // readback shows stored values; no radio rate exists here
    assign interface_rate_setting_o = rate_q;
    assign rate_busy_o              = (rst_q != R_IDLE);
    assign parity_setting_o         = par_q;
    assign packet_silence_timeout_o = to_q;
    assign cts_pin_function_o       = cfn_q;
    assign rts_pin_function_o       = rfn_q;

    logic [3:0]  nbits;               // bits per character
    assign nbits = BITS_NO_PAR + {3'h0, par_q != PAR_NONE};

    rx_state_t         rx_q, rx_d;    // receiver state
    logic [15:0]       rc_q, rc_d;    // receiver bit timer
    logic [3:0]        rb_q, rb_d;    // receiver bit index
    logic [7:0]        rs_q, rs_d;    // receive shifter
    logic [11:0]       idle_q, idle_d;// idle bit times
    logic              push;          // byte received
    drain_state_t      dr_q, dr_d;    // packet drain state
    logic [BUF_AW-1:0] wp_q, wp_d, rp_q, rp_d; // buffer pointers
    logic [7:0]        cnt_q, cnt_d;  // buffer fill
    logic [7:0]        rem8_q, rem8_d;// bytes left in packet
    logic              fetch, pop;    // buffer read / consume
    logic [11:0]       thr;           // silence threshold

    // receiver, silence timer, packetizer
    always_comb begin
        rx_d = rx_q; rc_d = rc_q + 16'h0001; rb_d = rb_q; rs_d = rs_q;
        idle_d = idle_q; push = 1'b0;
        unique case (rx_q)
            RX_IDLE: begin
                if (!uart_rx_i) begin
                    rx_d = RX_START; rc_d = '0;
                end else if (rc_q >= div_q - 16'h0001) begin
                    rc_d = '0;
                    if (idle_q != 12'hFFF) idle_d = idle_q + 12'h001;
                end
            end
            RX_START: if (rc_q == {1'b0, div_q[15:1]}) begin
                rx_d = uart_rx_i ? RX_IDLE : RX_DATA;
                rc_d = '0; rb_d = 4'h1;
            end
            default: if (rc_q >= div_q - 16'h0001) begin
                rc_d = '0; rb_d = rb_q + 4'h1;
                if (rb_q <= 4'h8) rs_d = {uart_rx_i, rs_q[7:1]};
                // parity bit is sampled and dropped unchecked
                if (rb_q == nbits - 4'h1) begin
                    push = (cnt_q != BUF_DEPTH);
                    idle_d = '0; rc_d = '0;
                    rx_d = RX_IDLE;
                end
            end
        endcase
        thr = 12'(to_q) * 12'(nbits);
        dr_d = dr_q; rem8_d = rem8_q; rp_d = rp_q; fetch = 1'b0; pop = 1'b0;
        unique case (dr_q)
            D_IDLE: if (cnt_q != 8'h00 && (cnt_q >= MAX_PAYLOAD ||
                    (!framed_mode_i && (to_q == 8'h00 ||
                     idle_q >= thr)))) begin
                rem8_d = (cnt_q >= MAX_PAYLOAD) ? MAX_PAYLOAD : cnt_q;
                dr_d = D_FETCH;
            end
            D_FETCH: begin
                fetch = 1'b1; dr_d = D_SEND;
            end
            default: if (rf_tx_ready_i) begin
                pop = 1'b1; rp_d = rp_q + 1'b1; rem8_d = rem8_q - 8'h01;
                dr_d = (rem8_q == 8'h01) ? D_IDLE : D_FETCH;
            end
        endcase
        wp_d  = push ? wp_q + 1'b1 : wp_q;
        cnt_d = cnt_q + {7'h00, push} - {7'h00, pop};
    end

    // receiver and packetizer registers
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rx_q <= RX_IDLE; rc_q <= '0; rb_q <= '0; rs_q <= '0;
            idle_q <= '0; dr_q <= D_IDLE; wp_q <= '0; rp_q <= '0;
            cnt_q <= '0; rem8_q <= '0;
        end else begin
            rx_q <= rx_d; rc_q <= rc_d; rb_q <= rb_d; rs_q <= rs_d;
            idle_q <= idle_d; dr_q <= dr_d; wp_q <= wp_d; rp_q <= rp_d;
            cnt_q <= cnt_d; rem8_q <= rem8_d;
        end
    end

    rx_buffer_mem u_mem (
        .sys_clk_i (sys_clk_i),
        .wr_en_i   (push),
        .wr_addr_i (wp_q),
        .wr_data_i (rs_d),
        .rd_en_i   (fetch),
        .rd_addr_i (rp_q),
        .rd_data_o (rf_tx_data_o)
    );
    assign rf_tx_valid_o = (dr_q == D_SEND);
    assign rf_tx_last_o  = (dr_q == D_SEND) && (rem8_q == 8'h01);

    logic [10:0] ts_q, ts_d;          // transmit shifter
    logic [3:0]  tb_q, tb_d;          // bits left to send
    logic [15:0] tc_q, tc_d;          // transmit bit timer
    logic        tx_q, tx_d;          // serial output
    logic        hold;                // host asks to pause
    logic        pb;                  // parity bit to send
    logic        c_q, c_d, ce_q, ce_d, ci_q, ci_d; // cts pin
    logic        r_q, r_d, re_q, re_d, ri_q, ri_d; // rts pin

    assign hold = (rfn_q == PIN_FLOW) && flow_pin_six_i;
    assign rf_rx_ready_o = (tb_q == 4'h0) && !hold;

    // transmitter and pin functions
    always_comb begin
        ts_d = ts_q; tb_d = tb_q; tc_d = tc_q + 16'h0001; tx_d = tx_q;
        unique case (par_q)
            PAR_EVEN: pb = ^rf_rx_data_i;
            PAR_ODD:  pb = ~^rf_rx_data_i;
            default:  pb = 1'b1; // mark, or stop when no parity
        endcase
        if (tb_q == 4'h0) begin
            tx_d = 1'b1;
            if (rf_rx_valid_i && !hold) begin
                ts_d = {2'b11, pb, rf_rx_data_i}; // start bit goes out now
                tb_d = nbits; tc_d = '0; tx_d = 1'b0;
            end
        end else if (tc_q >= div_q - 16'h0001) begin
            tc_d = '0; tb_d = tb_q - 4'h1;
            tx_d = (tb_q == 4'h1) ? 1'b1 : ts_q[0];
            ts_d = {1'b1, ts_q[10:1]};
        end
        c_d = 1'b0; ce_d = 1'b1;
        unique case (cfn_q)
            PIN_FLOW:   c_d = (cnt_d >= NEAR_FULL);
            PIN_HIGH:   c_d = 1'b1;
            PIN_LOW:    c_d = 1'b0;
            PIN_485_LO: c_d = (tb_d == 4'h0);
            PIN_485_HI: c_d = (tb_d != 4'h0);
            default:    ce_d = 1'b0;                  // off or input
        endcase
        ci_d = (cfn_q == PIN_DIN) && flow_pin_seven_i;
        r_d = (rfn_q == PIN_HIGH);
        re_d = (rfn_q == PIN_HIGH) || (rfn_q == PIN_LOW);
        ri_d = (rfn_q == PIN_DIN) && flow_pin_six_i;
    end

    // transmitter and pin registers
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ts_q <= '1; tb_q <= '0; tc_q <= '0; tx_q <= 1'b1;
            c_q <= 1'b0; ce_q <= 1'b1; ci_q <= 1'b0; // cts driven clear
            r_q <= 1'b0; re_q <= 1'b0; ri_q <= 1'b0;
        end else begin
            ts_q <= ts_d; tb_q <= tb_d; tc_q <= tc_d; tx_q <= tx_d;
            c_q <= c_d; ce_q <= ce_d; ci_q <= ci_d;
            r_q <= r_d; re_q <= re_d; ri_q <= ri_d;
        end
    end
    assign uart_tx_o            = tx_q;
    assign flow_pin_seven_o     = c_q;
    assign flow_pin_seven_oe_o  = ce_q;
    assign flow_pin_seven_din_o = ci_q;
    assign flow_pin_six_o       = r_q;
    assign flow_pin_six_oe_o    = re_q;
    assign flow_pin_six_din_o   = ri_q;

    // checks
    AST_STD_CODE: assert property (rate_wr_i && !rate_busy_o &&
        cfg_wdata_i <= STD_CODE_MAX |-> ##25 !rate_busy_o &&
        interface_rate_setting_o == $past(cfg_wdata_i, 25))
        else $error("code not stored");
    AST_BAD_RATE: assert property (rate_wr_i && !rate_busy_o &&
        cfg_wdata_i > STD_CODE_MAX && cfg_wdata_i < RATE_LIT_MIN
        |=> !rate_busy_o)
        else $error("bad rate accepted");
    AST_LIT_DONE: assert property (rate_wr_i && !rate_busy_o &&
        cfg_wdata_i >= RATE_LIT_MIN && cfg_wdata_i <= RATE_LIT_MAX
        |-> ##[40:60] !rate_busy_o)
        else $error("rate rounding hung");
    AST_PAR_KEEP: assert property (!parity_wr_i |=>
        $stable(parity_setting_o))
        else $error("parity changed");
    AST_FULL_SEND: assert property (dr_q == D_IDLE &&
        cnt_q >= MAX_PAYLOAD |=> dr_q == D_FETCH)
        else $error("full buffer not sent");
    AST_ZERO_TO: assert property (dr_q == D_IDLE &&
        cnt_q != 8'h00 && to_q == 8'h00 && !framed_mode_i
        |=> ##1 rf_tx_valid_o)
        else $error("byte not forwarded");
    AST_485_LO: assert property (cfn_q == PIN_485_LO &&
        $stable(cfn_q) |-> flow_pin_seven_o == (tb_q == 4'h0))
        else $error("low enable wrong");
    AST_485_HI: assert property (cfn_q == PIN_485_HI &&
        $stable(cfn_q) |->
        flow_pin_seven_o == (tb_q != 4'h0) && flow_pin_seven_oe_o)
        else $error("high enable wrong");
    AST_RTS_HOLD: assert property (hold && tb_q == 4'h0 |=>
        tb_q == 4'h0)
        else $error("sent while held");
    AST_CTS_FULL: assert property (cfn_q == PIN_FLOW &&
        $stable(cfn_q) && cnt_q >= NEAR_FULL |-> flow_pin_seven_o)
        else $error("cts not deasserted");
    COV_PACKET: cover property (@(posedge sys_clk_i) rf_tx_last_o &&
        rf_tx_ready_i);
    COV_LIT: cover property (@(posedge sys_clk_i) rst_q == R_DIV2 ##1
        rst_q == R_IDLE);
    COV_TX: cover property (@(posedge sys_clk_i) rf_rx_valid_i &&
        rf_rx_ready_o);
endmodule

//--- test/host_uart_model.sv
// host side model: sends and receives characters on the serial pins
// assumes the bench sets the bit time in clocks to match the device
`timescale 1ns/1ps
module host_uart_model (
    input  wire logic sys_clk_i,
    input  wire logic line_from_dev_i,
    output logic      line_to_dev_o,
    output logic      rts_o
);
    int bit_clk = 87; // clocks per bit
    // idle line high, host lets the device send
    initial begin
        line_to_dev_o = 1'b1;
        rts_o         = 1'b0;
    end
    // host asks the device to hold its serial output
    task automatic hold(input logic h);
        rts_o = h;
    endtask
    // one character; parity bit chosen by caller, maybe wrong
    task automatic send(input logic [7:0] b, input logic pe, pb);
        logic [10:0] f;
        f = pe ? {1'b1, pb, b, 1'b0} : {2'b11, b, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge sys_clk_i);
            #1;
            line_to_dev_o = f[i];
            repeat (bit_clk - 1) @(posedge sys_clk_i);
        end
    endtask
    // wait for a start bit under a bound, sample at mid bit
    task automatic recv(output logic [7:0] b);
        b = 'x;
        for (int i = 0; i < 4000 && line_from_dev_i; i++)
            @(posedge sys_clk_i);
        repeat (bit_clk / 2) @(posedge sys_clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (bit_clk) @(posedge sys_clk_i);
            b[i] = line_from_dev_i;
        end
    endtask
endmodule

//--- test/host_serial_port_config_tb_top.sv
// bench for the host serial port: settings, packets, serial out
// assumes the package, design and host model compile first
`timescale 1ns/1ps
module host_serial_port_config_tb_top;
    import serial_cfg_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, framed = 1'b0;
    logic        rf_v = 1'b0, ext7 = 1'b0, tx, rx, tv, tl, busy, rdy = 1'b1;
    logic        rrdy, p7o, p7oe, p7din, rts, lst;
    logic [4:0]  wr = '0;   // rate, parity, timeout, cts, rts strobes
    logic [19:0] wd = '0, rate;
    logic [7:0]  rf_d = '0, td, tmo, b;
    logic [1:0]  par;
    logic [2:0]  cfn, rfn;
    logic [7:0]  got[$];    // bytes handed to the radio side
    int          n_fail = 0, n_tests = 0;
    host_serial_port_config u_host_serial_port_config (
        .sys_clk_i(clk), .rst_i(rst), .rate_wr_i(wr[0]),
        .parity_wr_i(wr[1]), .timeout_wr_i(wr[2]), .cts_fn_wr_i(wr[3]),
        .rts_fn_wr_i(wr[4]), .cfg_wdata_i(wd), .framed_mode_i(framed),
        .interface_rate_setting_o(rate), .rate_busy_o(busy),
        .parity_setting_o(par), .packet_silence_timeout_o(tmo),
        .cts_pin_function_o(cfn), .rts_pin_function_o(rfn),
        .uart_rx_i(rx), .uart_tx_o(tx), .rf_tx_valid_o(tv),
        .rf_tx_data_o(td), .rf_tx_last_o(tl), .rf_tx_ready_i(rdy),
        .rf_rx_valid_i(rf_v), .rf_rx_data_i(rf_d), .rf_rx_ready_o(rrdy),
        .flow_pin_seven_i(p7oe ? p7o : ext7), .flow_pin_seven_o(p7o),
        .flow_pin_seven_oe_o(p7oe), .flow_pin_seven_din_o(p7din),
        .flow_pin_six_i(rts), .flow_pin_six_o(), .flow_pin_six_oe_o(),
        .flow_pin_six_din_o());
    host_uart_model u_host_uart_model (.sys_clk_i(clk),
        .line_from_dev_i(tx), .line_to_dev_o(rx), .rts_o(rts));
    // 10 MHz clock
    initial forever #50 clk = ~clk;
    // collect radio bytes taken while ready
    always @(posedge clk) if (tv === 1'b1 && rdy === 1'b1) begin
        got.push_back(td);
        lst <= tl;
    end
    task automatic step;
        @(posedge clk);
        #1;
    endtask
    task automatic check(input string nm, input logic [19:0] s, e);
        n_tests++;
        if (s !== e) begin
            n_fail++;
            $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
        end
    endtask
    // one setting strobe, then wait out a rate computation
    task automatic set(input int k, input logic [19:0] v);
        step;
        wr[k] = 1'b1;
        wd = v;
        step;
        wr = '0;
        for (int i = 0; i < 99 && busy !== 1'b0; i++) step;
        if (busy !== 1'b0) n_fail++;
        step;
    endtask
    // hand one byte to the serial transmitter
    task automatic push(input logic [7:0] v);
        step;
        rf_v = 1'b1;
        rf_d = v;
        for (int i = 0; i < 99 && rrdy !== 1'b1; i++) step;
        if (rrdy !== 1'b1) n_fail++;
        step;
        rf_v = 1'b0;
    endtask
    // nearest divider, then the rate it really gives
    function automatic logic [19:0] ach(input int r);
        int d;
        d = (10_000_000 + r / 2) / r;
        return 20'((10_000_000 + d / 2) / d);
    endfunction
    task automatic wrap_up;
        $display("checks %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // cut a hang short
    initial begin
        repeat (95000) @(posedge clk);
        n_fail++;
        wrap_up;
    end
    initial begin
        repeat (6) step;
        rst = 1'b0;
        check("rate", rate, 20'h0_0003);
        check("parity", par, 2'h0);
        check("timeout", tmo, 8'h03);
        check("fns", {cfn, rfn}, 6'h08);
        check("idle", {p7oe, p7o, tx, tv, rrdy}, 5'h15);
        set(0, 20'h0_E100);
        check("lit", rate, ach(57600));
        set(0, 20'h0_04B0);
        check("lit_min", rate, ach(1200));
        set(0, 20'h3_D090);
        check("lit_max", rate, ach(250000));
        set(0, 20'h0_04AF);
        set(0, 20'h0_0009);
        check("refused", rate, 20'h3_D090);
        for (int i = 0; i < 9; i++) begin
            set(0, 20'(i));
            check("code", rate, 20'(i));
        end
        for (int i = 0; i < 4; i++) begin
            set(1, 20'(i));
            check("par_set", par, 20'(i));
        end
        // 115200 b/s, odd parity, wrong parity bits sent
        set(0, 20'h0_0007);
        set(1, 20'h0_0002);
        got = {};
        u_host_uart_model.send(8'h3C, 1'b1, 1'b0);
        u_host_uart_model.send(8'hC5, 1'b1, 1'b0);
        repeat (1700) step;
        check("early", 20'(got.size()), 20'h0);
        for (int i = 0; i < 3000 && got.size() < 2; i++) step;
        check("pkt", {got[0], got[1]}, 16'h3CC5);
        check("last", {19'(got.size()), lst}, 20'h0_0005);
        set(2, 20'h0_0000);
        got = {};
        u_host_uart_model.send(8'h5A, 1'b1, 1'b1);
        for (int i = 0; i < 400 && got.size() < 1; i++) step;
        check("single", {got[0], lst}, 9'h0B5);
        // transmit enable polarity around a serial byte
        for (int f = 7; f > 5; f--) begin
            set(3, 20'(f));
            push(8'hA5);
            fork
                u_host_uart_model.recv(b);
                begin
                    repeat (300) step;
                    check("en_tx", p7o, 20'(f == 7));
                end
            join
            check("tx_byte", b, 8'hA5);
            repeat (400) step;
            check("en_idle", p7o, 20'(f == 6));
        end
        for (int f = 4; f < 6; f++) begin
            set(3, 20'(f));
            check("pin_out", {p7oe, p7o}, 20'(f - 2));
        end
        ext7 = 1'b1;
        set(3, 20'h0_0003);
        check("pin_in", {p7oe, p7din}, 2'b01);
        set(4, 20'h0_0001);
        u_host_uart_model.hold(1'b1);
        repeat (3) step;
        check("rts_hold", rrdy, 1'b0);
        u_host_uart_model.hold(1'b0);
        repeat (3) step;
        check("rts_go", rrdy, 1'b1);
        framed = 1'b1;
        set(2, 20'h0_0003);
        got = {};
        u_host_uart_model.send(8'h77, 1'b1, 1'b1);
        repeat (4000) step;
        check("framed", 20'(got.size()), 20'h0);
        // full payload and cts flow with the radio side stalled
        set(0, 20'h0_0008);
        set(3, 20'h0_0001);
        u_host_uart_model.bit_clk = 43; // 10 MHz / 230400 rounded
        rdy = 1'b0;
        for (int i = 0; i < 111; i++)
            u_host_uart_model.send(8'(i), 1'b1, 1'b0);
        step;
        check("cts_full", p7o, 1'b1);
        check("full_wait", {tv, 19'(got.size())}, 20'h8_0000);
        rdy = 1'b1;
        repeat (250) step;
        check("full_pkt", {got[0], got[99], lst}, 20'h0_EEC5);
        check("full_cnt", 20'(got.size()), 20'h0_0064);
        check("cts_free", p7o, 1'b0);
        wrap_up;
    end
endmodule
